/* mcs_params.svh */
// offsets, field positions, reset values and counts of the mac config block
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// register byte offsets, each register has write/clear/set/invert aliases
`define MCS_CFG_BASE 8'h00
`define MCS_SA_BASE 8'h10
`define MCS_ALIAS_CLR 2'h1
`define MCS_ALIAS_SET 2'h2
`define MCS_ALIAS_INV 2'h3

// configuration field positions
`define MCS_CFG_WHOLE_RST 15
`define MCS_CFG_RNG_RST 14
`define MCS_CFG_RX_CS_RST 11
`define MCS_CFG_RX_FN_RST 10
`define MCS_CFG_TX_CS_RST 9
`define MCS_CFG_TX_FN_RST 8
`define MCS_CFG_LOOPBACK 4
`define MCS_CFG_TX_PAUSE 3
`define MCS_CFG_RX_PAUSE 2
`define MCS_CFG_PASS_ALL 1
`define MCS_CFG_RX_ON 0

// reset values and implemented-bit masks
`define MCS_CFG_RESET 16'h800D
`define MCS_CFG_IMPL 16'hCF1F
`define MCS_SA_IMPL 16'hFFFF

// station address octet positions
`define MCS_SA_FIRST_LSB 0
`define MCS_SA_SECOND_LSB 8

// cycles after reset release before the synchronised factory address holds
`define MCS_SA_LOAD_WAIT 2'h2

`endif

/* mcs_pkg.sv */
// types shared by the mac configuration block
package mcs_pkg;

  // kind of register update chosen by the alias offset
  typedef enum logic [3:0]
  {
    MCS_OP_WRITE = 4'b0001,
    MCS_OP_CLR = 4'b0010,
    MCS_OP_SET = 4'b0100,
    MCS_OP_INV = 4'b1000
  } mcs_op_e;

  // bus slave phase
  typedef enum logic [1:0]
  {
    MCS_ST_IDLE = 2'b01,
    MCS_ST_DONE = 2'b10
  } mcs_bus_e;

endpackage

/* mcs_sync.sv */
// two flip-flop synchroniser for signals arriving from pins
`timescale 1ns/1ns
module mcs_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_r;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("mcs_sync: WIDTH must be at least 1");
    end
  end

  // both stages clear under reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // mcs_sync

/* mcs_mac_config.sv */
// mac configuration and station address registers behind an apb slave
//
// What this block does
// - soft reset bit 15 holds whole mac, resets high
// - bit 14 resets the transmit random generator
// - bit 11 resets receive control sublayer
// - bit 10 resets receive function logic
// - bit 9 resets transmit control sublayer
// - bit 8 resets transmit function logic
// - bit 4 loops transmit back into receive
// - bit 3 allows or blocks sending pause frames
// - bit 2 acts on or ignores received pause
// - bit 1 passes control frames, else dropped
// - bit 0 enables frame reception
// - 16/32-bit accesses work, 8-bit ignored
// - address bits 7-0 first octet, 15-8 second
// - station address loads factory value after reset release
// - unimplemented config bits read zero, ignore writes
`timescale 1ns/1ns
`include "mcs_params.svh"
module mcs_mac_config
  import mcs_pkg::*;
#(
  parameter int MII_WIDTH = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // factory station address pins
  input wire logic [15:0] factory_addr,
  // mac datapath hooks on this clock
  input wire logic [MII_WIDTH-1:0] mac_txd,
  input wire logic mac_tx_en,
  input wire logic pause_tx_req,
  input wire logic pause_rx_seen,
  input wire logic rx_frame_valid,
  input wire logic rx_frame_is_ctrl,
  // receive pins from the phy
  input wire logic [MII_WIDTH-1:0] phy_rxd,
  input wire logic phy_rx_dv,
  // resets out to the mac domains, active high
  output logic mac_whole_reset,
  output logic tx_random_generator_reset,
  output logic rx_control_sublayer_reset,
  output logic rx_function_reset,
  output logic tx_control_sublayer_reset,
  output logic tx_function_reset,
  // mode and gating outputs
  output logic [MII_WIDTH-1:0] mac_rxd,
  output logic mac_rx_dv,
  output logic pause_tx_go,
  output logic pause_rx_act,
  output logic rx_frame_accept,
  output logic frame_receive_on,
  output logic [7:0] station_octet_first,
  output logic [7:0] station_octet_second
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  initial
  begin
    if (MII_WIDTH < 1 || MII_WIDTH > 8)
    begin
      $error("mcs_mac_config: MII_WIDTH must be 1 to 8");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_r; // first release stage
  logic rst_n; // released reset used by the rest

  // assert at once, release after two edges so no flop sees a ragged edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [15:0] factory_sync; // settled factory address
  logic [MII_WIDTH:0] phy_sync; // settled receive pins

  // factory straps cross from pins
  mcs_sync #(.WIDTH(16)) u_factory_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .d(factory_addr),
    .q(factory_sync)
  );

  // phy receive pins cross from the phy
  mcs_sync #(.WIDTH(MII_WIDTH + 1)) u_phy_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .d({phy_rx_dv, phy_rxd}),
    .q(phy_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed
  {
    mcs_bus_e bus; // apb phase
    logic [15:0] cfg; // configuration bits
    logic [15:0] sa; // station address low octets
    logic [1:0] load_cnt; // wait for factory value
    logic loaded; // factory value taken
    logic [31:0] prdata; // read answer
    logic pready; // answer strobe
    logic pslverr; // unmapped answer
    logic [MII_WIDTH-1:0] rxd; // receive data to mac
    logic rx_dv; // receive valid to mac
    logic pause_tx_go; // gated pause send
    logic pause_rx_act; // gated pause action
    logic rx_accept; // gated frame accept
    logic [5:0] rst_out; // domain resets
  } mcs_state_s;

  mcs_state_s st_r; // registered state
  mcs_state_s st_nxt; // next state

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  logic access; // access phase present
  logic is_cfg; // config register hit
  logic is_sa; // station address hit
  logic lanes_ok; // 16 or 32 bit lane pattern
  logic [31:0] lane_mask; // byte lanes expanded
  mcs_op_e op; // alias kind

  // decode target, alias and lane pattern
  always_comb
  begin
    access = psel && penable;
    is_cfg = ((paddr & 8'hF3) == `MCS_CFG_BASE); // alias bits masked
    is_sa = ((paddr & 8'hF3) == `MCS_SA_BASE); // word slots only
    // byte strobes alone are refused; halfword or word only
    lanes_ok = (pstrb == 4'hF) || (pstrb == 4'h3) ||
               (pstrb == 4'hC);
    lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                 {8{pstrb[1]}}, {8{pstrb[0]}}};
    case (paddr[3:2])
      `MCS_ALIAS_CLR: op = MCS_OP_CLR;
      `MCS_ALIAS_SET: op = MCS_OP_SET;
      `MCS_ALIAS_INV: op = MCS_OP_INV;
      default: op = MCS_OP_WRITE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register update through the aliases

  // apply one alias operation to a 16-bit register, keeping only impl bits
  function automatic logic [15:0] apply_op
  (
    input mcs_op_e kind,
    input logic [15:0] old,
    input logic [15:0] wd,
    input logic [15:0] m,
    input logic [15:0] impl
  );
    logic [15:0] r;
    r = old;
    case (kind)
      MCS_OP_WRITE: r = (old & ~m) | (wd & m);
      MCS_OP_CLR: r = old & ~(wd & m);
      MCS_OP_SET: r = old | (wd & m);
      MCS_OP_INV: r = old ^ (wd & m);
      default: r = old;
    endcase
    return r & impl;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // one combinational pass over bus, load and mac gating
  always_comb
  begin
    st_nxt = st_r;

    // bus handshake: answer one cycle into the access phase
    case (st_r.bus)
      MCS_ST_IDLE:
      begin
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (access)
        begin
          st_nxt.bus = MCS_ST_DONE;
          st_nxt.pready = 1'b1;
          st_nxt.pslverr = !(is_cfg || is_sa);
          // reads give the whole word; upper halves read zero
          if (is_cfg)
          begin
            st_nxt.prdata = {16'h0000, st_r.cfg & `MCS_CFG_IMPL};
          end
          else if (is_sa)
          begin
            st_nxt.prdata = {16'h0000, st_r.sa};
          end
          else
          begin
            st_nxt.prdata = 32'h0000_0000;
          end
        end
      end
      MCS_ST_DONE:
      begin
        // write takes effect on the edge that samples pready
        st_nxt.bus = MCS_ST_IDLE;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (access && pwrite && lanes_ok)
        begin
          if (is_cfg)
          begin
            st_nxt.cfg = apply_op(op, st_r.cfg, pwdata[15:0],
                                  lane_mask[15:0],
                                  `MCS_CFG_IMPL);
          end
          else if (is_sa)
          begin
            // upper half of the word is dropped, software keeps it zero
            st_nxt.sa = apply_op(op, st_r.sa, pwdata[15:0],
                                 lane_mask[15:0],
                                 `MCS_SA_IMPL);
          end
        end
      end
      default:
      begin
        st_nxt.bus = MCS_ST_IDLE;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
      end
    endcase

    // factory station address taken once the pins have settled
    if (!st_r.loaded)
    begin
      if (st_r.load_cnt == `MCS_SA_LOAD_WAIT)
      begin
        st_nxt.sa = factory_sync;
        st_nxt.loaded = 1'b1;
      end
      else
      begin
        st_nxt.load_cnt = st_r.load_cnt + 2'h1;
      end
    end

    // domain resets follow their bits; whole reset covers every domain
    st_nxt.rst_out[5] = st_r.cfg[`MCS_CFG_WHOLE_RST];
    st_nxt.rst_out[4] = st_r.cfg[`MCS_CFG_RNG_RST] ||
                        st_r.cfg[`MCS_CFG_WHOLE_RST];
    st_nxt.rst_out[3] = st_r.cfg[`MCS_CFG_RX_CS_RST] ||
                        st_r.cfg[`MCS_CFG_WHOLE_RST];
    st_nxt.rst_out[2] = st_r.cfg[`MCS_CFG_RX_FN_RST] ||
                        st_r.cfg[`MCS_CFG_WHOLE_RST];
    st_nxt.rst_out[1] = st_r.cfg[`MCS_CFG_TX_CS_RST] ||
                        st_r.cfg[`MCS_CFG_WHOLE_RST];
    st_nxt.rst_out[0] = st_r.cfg[`MCS_CFG_TX_FN_RST] ||
                        st_r.cfg[`MCS_CFG_WHOLE_RST];

    // loopback steers mac transmit into mac receive
    if (st_r.cfg[`MCS_CFG_LOOPBACK])
    begin
      st_nxt.rxd = mac_txd;
      st_nxt.rx_dv = mac_tx_en;
    end
    else
    begin
      st_nxt.rxd = phy_sync[MII_WIDTH-1:0];
      st_nxt.rx_dv = phy_sync[MII_WIDTH];
    end

    // pause frames may leave only while allowed
    st_nxt.pause_tx_go = pause_tx_req &&
                         st_r.cfg[`MCS_CFG_TX_PAUSE];
    // received pause acted on only while honoured
    st_nxt.pause_rx_act = pause_rx_seen &&
                          st_r.cfg[`MCS_CFG_RX_PAUSE];
    // receive gate, then control frames dropped unless passing all
    st_nxt.rx_accept = rx_frame_valid &&
                       st_r.cfg[`MCS_CFG_RX_ON] &&
                       (!rx_frame_is_ctrl ||
                        st_r.cfg[`MCS_CFG_PASS_ALL]);

    // a held receive function reset also blocks acceptance and pause action
    if (st_r.rst_out[2])
    begin
      st_nxt.rx_accept = 1'b0;
      st_nxt.pause_rx_act = 1'b0;
    end
    // transmit control sublayer in reset sends no pause
    if (st_r.rst_out[1])
    begin
      st_nxt.pause_tx_go = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // constants only under reset; factory value arrives after release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.bus <= MCS_ST_IDLE;
      st_r.cfg <= `MCS_CFG_RESET;
      st_r.sa <= 16'h0000;
      st_r.load_cnt <= 2'h0;
      st_r.loaded <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.rxd <= '0;
      st_r.rx_dv <= 1'b0;
      st_r.pause_tx_go <= 1'b0;
      st_r.pause_rx_act <= 1'b0;
      st_r.rx_accept <= 1'b0;
      // whole reset starts asserted, so every domain starts held
      st_r.rst_out <= 6'h3F;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign mac_whole_reset = st_r.rst_out[5];
  assign tx_random_generator_reset = st_r.rst_out[4];
  assign rx_control_sublayer_reset = st_r.rst_out[3];
  assign rx_function_reset = st_r.rst_out[2];
  assign tx_control_sublayer_reset = st_r.rst_out[1];
  assign tx_function_reset = st_r.rst_out[0];
  assign mac_rxd = st_r.rxd;
  assign mac_rx_dv = st_r.rx_dv;
  assign pause_tx_go = st_r.pause_tx_go;
  assign pause_rx_act = st_r.pause_rx_act;
  assign rx_frame_accept = st_r.rx_accept;
  assign frame_receive_on = st_r.cfg[`MCS_CFG_RX_ON];
  // first transmitted octet sits in the low byte
  assign station_octet_first =
    st_r.sa[`MCS_SA_FIRST_LSB +: 8];
  assign station_octet_second =
    st_r.sa[`MCS_SA_SECOND_LSB +: 8];

endmodule // mcs_mac_config

/* mcs_mac_config_props.sv */
// port assertions for the mac configuration block
`timescale 1ns/1ns
module mcs_mac_config_props
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pause_tx_req,
  input wire logic pause_rx_seen,
  input wire logic rx_frame_valid,
  input wire logic mac_whole_reset,
  input wire logic tx_random_generator_reset,
  input wire logic rx_control_sublayer_reset,
  input wire logic rx_function_reset,
  input wire logic tx_control_sublayer_reset,
  input wire logic tx_function_reset,
  input wire logic pause_tx_go,
  input wire logic pause_rx_act,
  input wire logic rx_frame_accept,
  input wire logic [7:0] station_octet_first,
  input wire logic [7:0] station_octet_second
);
  ////////////////////////////////////////////////////////////////////////////
  // one clock domain, so defaults carry clock and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // apb answer: a single pulse, only after an access phase
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_cause: assert property (pready |->
    $past(psel && penable))
    else $error("ready without access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // whole reset drags every domain reset with it
  chk_whole_all: assert property (mac_whole_reset |->
    tx_random_generator_reset && rx_control_sublayer_reset &&
    rx_function_reset && tx_control_sublayer_reset && tx_function_reset)
    else $error("domain reset low under whole reset");
  // held domain resets block their gated outputs
  chk_txcs_block: assert property (tx_control_sublayer_reset &&
    $past(tx_control_sublayer_reset) |-> !pause_tx_go)
    else $error("pause sent under tx reset");
  chk_rxfn_block: assert property (rx_function_reset &&
    $past(rx_function_reset) |-> !rx_frame_accept && !pause_rx_act)
    else $error("receive active under rx reset");
  chk_pause_cause: assert property (pause_tx_go |->
    $past(pause_tx_req))
    else $error("pause sent without request");
  chk_rx_flow_control_honour_cause: assert property (pause_rx_act |->
    $past(pause_rx_seen))
    else $error("pause acted without frame");
  chk_accept_cause: assert property (rx_frame_accept |->
    $past(rx_frame_valid))
    else $error("frame accepted without frame");
  // full word write to the address register shows on the octets
  chk_sa_write: assert property (psel && penable && pready &&
    pwrite && paddr == 8'h10 && pstrb == 4'hF |->
    ##2 {station_octet_second, station_octet_first} == $past(pwdata[15:0], 2))
    else $error("station octets differ from write");
  // config reads keep unimplemented positions at zero
  chk_cfg_zero: assert property (psel && penable && pready &&
    !pwrite && paddr[7:4] == 4'h0 |-> (prdata & 32'hFFFF30E0) == 32'h0)
    else $error("unimplemented config bit set");
endmodule // mcs_mac_config_props

bind mcs_mac_config mcs_mac_config_props mcs_mac_config_props_inst
(
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .pause_tx_req, .pause_rx_seen, .rx_frame_valid,
  .mac_whole_reset, .tx_random_generator_reset, .rx_control_sublayer_reset,
  .rx_function_reset, .tx_control_sublayer_reset, .tx_function_reset,
  .pause_tx_go, .pause_rx_act, .rx_frame_accept, .station_octet_first,
  .station_octet_second
);

/* mcs_phy_model.sv */
// receive side of a media phy feeding nibbles on its pins
`timescale 1ns/1ns
module mcs_phy_model
(
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] nib,
  output logic [3:0] phy_rxd,
  output logic phy_rx_dv
);
  initial
  begin
    phy_rxd = 4'h0;
    phy_rx_dv = 1'b0;
  end
  // outside frames data toggles, so stale data never looks valid
  always @(posedge clk)
  begin
    phy_rx_dv <= go;
    phy_rxd <= go ? nib : ~phy_rxd;
  end
endmodule // mcs_phy_model

/* mac_config_and_station_address_bench.sv */
// self-checking bench for the mac configuration block
`timescale 1ns/1ns
`include "mcs_params.svh"
module mac_config_and_station_address_bench;
  localparam logic [15:0] FACTORY = 16'hA55A; // arbitrary pattern
  logic clk, rst_b, psel, penable, pwrite, mac_tx_en, pause_tx_req, go;
  logic pause_rx_seen, rx_frame_valid, rx_frame_is_ctrl, phy_rx_dv;
  logic pready, pslverr, er, mac_rx_dv, pause_tx_go, pause_rx_act;
  logic rx_frame_accept, frame_receive_on, mac_whole_reset;
  logic tx_random_generator_reset, rx_control_sublayer_reset;
  logic rx_function_reset, tx_control_sublayer_reset, tx_function_reset;
  logic [7:0] paddr, station_octet_first, station_octet_second;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, mac_txd, phy_rxd, mac_rxd, nib;
  logic [15:0] factory_addr;
  logic [5:0] rsts; // all domain resets, whole first
  int mismatches, checks;
  assign rsts = {mac_whole_reset, tx_random_generator_reset,
    rx_control_sublayer_reset, rx_function_reset,
    tx_control_sublayer_reset, tx_function_reset};
  mcs_mac_config mcs_mac_config_inst
  (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .factory_addr, .mac_txd, .mac_tx_en,
    .pause_tx_req, .pause_rx_seen, .rx_frame_valid, .rx_frame_is_ctrl,
    .phy_rxd, .phy_rx_dv, .mac_whole_reset, .tx_random_generator_reset,
    .rx_control_sublayer_reset, .rx_function_reset,
    .tx_control_sublayer_reset, .tx_function_reset, .mac_rxd, .mac_rx_dv,
    .pause_tx_go, .pause_rx_act, .rx_frame_accept, .frame_receive_on,
    .station_octet_first, .station_octet_second
  );
  mcs_phy_model mcs_phy_model_inst
  (
    .clk, .go, .nib, .phy_rxd, .phy_rx_dv
  );
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // k edges, then past the edge so outputs have landed
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one apb transfer; read data taken at the ready edge
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(8'h00, 1'b0, 32'h0, 4'hF);
    check(rd, {16'h0, 16'h800D});
    check(32'(rsts), 32'h3F);
    apb(8'h10, 1'b0, 32'h0, 4'hF);
    check(rd, {16'h0, FACTORY});
    check(32'({station_octet_second, station_octet_first}),
      32'(FACTORY));
    $display("reset test done");
  endtask
  // each row: config value, then all resets and gated outputs
  task automatic t_gate();
    logic [15:0] tab [8];
    logic [15:0] c;
    logic [5:0] e6;
    logic [3:0] e4;
    logic w, t;
    tab = '{16'h000F, 16'h0009, 16'h0006, 16'h0001, 16'h0C0F, 16'h030F,
      16'h400F, 16'h800F};
    for (int i = 0; i < 8; i++)
    begin
      c = tab[i];
      w = c[15];
      t = c[10] | w;
      e6 = {w, c[14] | w, c[11] | w, t, c[9] | w, c[8] | w};
      e4 = {c[3] & ~(c[9] | w), c[2] & ~t, c[0] & (~i[0] | c[1]) & ~t, c[0]};
      apb(8'h00, 1'b1, {16'h0, c}, 4'hF);
      @(posedge clk);
      rx_frame_is_ctrl <= i[0];
      settle(3);
      check(32'(rsts), 32'(e6));
      check(32'({pause_tx_go, pause_rx_act, rx_frame_accept,
        frame_receive_on}), 32'(e4));
    end
    // requests withdrawn while allowed: nothing may pass
    apb(8'h00, 1'b1, 32'h0000000F, 4'hF);
    {pause_tx_req, pause_rx_seen, rx_frame_valid} <= 3'h0;
    settle(3);
    check(32'({pause_tx_go, pause_rx_act, rx_frame_accept}),
      32'h0);
    @(posedge clk);
    {pause_tx_req, pause_rx_seen, rx_frame_valid} <= 3'h7;
    settle(3);
    check(32'({pause_tx_go, pause_rx_act, rx_frame_accept}),
      32'h7);
    $display("gating test done");
  endtask
  // aliases, lane strobes and the unmapped hole
  task automatic t_alias();
    logic [7:0] a [8];
    logic [31:0] d [8];
    logic [3:0] s [8];
    logic [15:0] x [8];
    a = '{8'h08, 8'h04, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h10, 8'h18};
    d = '{32'hFFFFFFFF, 32'h0000CF00, 32'h00000011, 32'h0000FFFF,
      32'h00000013, 32'hFFFF0000, 32'h00001234, 32'h0000C000};
    s = '{4'hF, 4'hF, 4'hF, 4'h1, 4'h3, 4'hC, 4'hF, 4'h3};
    x = '{16'hCF1F, 16'h001F, 16'h000E, 16'h000E, 16'h0013, 16'h0013,
      16'h1234, 16'hD234};
    apb(8'h00, 1'b1, 32'h0, 4'hF);
    for (int i = 0; i < 8; i++)
    begin
      apb(a[i], 1'b1, d[i], s[i]);
      apb(a[i] & 8'hF0, 1'b0, 32'h0, 4'hF);
      check(rd, {16'h0, x[i]});
    end
    apb(8'h20, 1'b0, 32'h0, 4'hF);
    check(rd, 32'h0);
    check(32'(er), 32'h1);
    $display("alias test done");
  endtask
  // loopback against phy pins with both sources active
  task automatic t_loop();
    apb(8'h00, 1'b1, 32'h11, 4'hF);
    @(posedge clk);
    mac_txd <= 4'hA;
    mac_tx_en <= 1'b1;
    go <= 1'b1;
    nib <= 4'h5;
    settle(6);
    check(32'({mac_rx_dv, mac_rxd}), 32'h1A);
    apb(8'h00, 1'b1, 32'h01, 4'hF);
    settle(6);
    check(32'({mac_rx_dv, mac_rxd}), 32'h15);
    @(posedge clk);
    go <= 1'b0;
    settle(6);
    check(32'(mac_rx_dv), 32'h0);
    $display("loopback test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {mac_txd, mac_tx_en, go, nib, rx_frame_is_ctrl} = '0;
    {pause_tx_req, pause_rx_seen, rx_frame_valid} = 3'h7;
    factory_addr = FACTORY;
    mismatches = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_gate();
    t_alias();
    t_loop();
    // mid-run reset must restore reset values and reload the address
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    end_of_test();
  end
endmodule // mac_config_and_station_address_bench
